//--- core/spt_defs.vh
// offsets, field positions, reset value, masks, mode codes and divider codes of the single channel timer
`ifndef SPT_DEFS_VH
`define SPT_DEFS_VH

`define SPT_OFF_CONTROL_ONE 8'h00
`define SPT_OFF_SLAVE_CONTROL 8'h08
`define SPT_OFF_IRQ_DMA_ENABLE 8'h0C
`define SPT_OFF_STATUS_FLAGS 8'h10
`define SPT_OFF_EVENT_GENERATE 8'h14
`define SPT_OFF_CHANNEL_MODE 8'h18
`define SPT_OFF_CHANNEL_ENABLE 8'h20
`define SPT_OFF_COUNTER_VALUE 8'h24
`define SPT_OFF_PRESCALER_VALUE 8'h28
`define SPT_OFF_RELOAD_VALUE 8'h2C
`define SPT_OFF_CHANNEL_ONE_COMPARE 8'h34
`define SPT_OFF_OPTION_SELECT 8'h50

`define SPT_RESET_VALUE 16'h0000

`define SPT_CTL_COUNT_RUN 0
`define SPT_CTL_UPDATE_BLOCK 1
`define SPT_CTL_UPDATE_SOURCE 2
`define SPT_CTL_RELOAD_BUFFER 7
`define SPT_CTL_DIV_LO 8
`define SPT_CTL_DIV_HI 9
`define SPT_CTL_MASK 16'h0387

`define SPT_SLV_TRIGGER_MODE 0
`define SPT_SLV_TRIGGER_UPDATE 1
`define SPT_SLV_MASK 16'h0003

`define SPT_IEN_MASK 16'h0003
`define SPT_STS_UPDATE 0
`define SPT_STS_COMPARE 1
`define SPT_EVG_UPDATE 0
`define SPT_EVG_COMPARE 1

`define SPT_CCM_DIR_LO 0
`define SPT_CCM_DIR_HI 1
`define SPT_CCM_CMP_BUFFER 3
`define SPT_CCM_MODE_LO 4
`define SPT_CCM_MODE_HI 6
`define SPT_CCM_MASK 16'h007B
`define SPT_CCM_DIR_OUTPUT 2'b00

`define SPT_MODE_FREEZE 3'b000
`define SPT_MODE_SET_ON_MATCH 3'b001
`define SPT_MODE_CLEAR_ON_MATCH 3'b010
`define SPT_MODE_TOGGLE 3'b011
`define SPT_MODE_FORCE_LOW 3'b100
`define SPT_MODE_FORCE_HIGH 3'b101
`define SPT_MODE_PWM_ONE 3'b110
`define SPT_MODE_PWM_TWO 3'b111

`define SPT_CEN_OUT_ENABLE 0
`define SPT_CEN_POLARITY 1
`define SPT_CEN_MASK 16'h0003
`define SPT_OPT_MASK 16'h0003

`define SPT_DIV_ONE 2'b00
`define SPT_DIV_TWO 2'b01
`define SPT_DIV_FOUR 2'b10

`endif

//--- core/spt_sample_div.v
// sampling period tick generator for the trigger filter clock
`timescale 1ns/100ps
`default_nettype none
`include "spt_defs.vh"

module spt_sample_div (
   input wire hclk,
   input wire hresetn,
   input wire [1:0] div_sel,
   output reg sample_tick
);
   reg [1:0] div_cnt;
   reg [1:0] div_last;

   // terminal count per divider choice, reserved code acts as one period
   always @* begin // see R13
      case (div_sel)
         `SPT_DIV_ONE: div_last = 2'd0;
         `SPT_DIV_TWO: div_last = 2'd1;
         `SPT_DIV_FOUR: div_last = 2'd3;
         default: div_last = 2'd0; // see R17
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt <= 2'd0;
         sample_tick <= 1'b0;
      end else if (div_cnt >= div_last) begin
         div_cnt <= 2'd0;
         sample_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 2'd1;
         sample_tick <= 1'b0;
      end
   end
endmodule // spt_sample_div

`default_nettype wire

//--- core/spt_timer.v
// single channel pwm timer with ahb-lite register slave
// What this block does
// R1 - pwm mode 2: reference inactive while counter below compare, else active
// R2 - forced mode ignores compare result and drives the chosen level
// R3 - direction field 00 makes the channel an output
// R4 - mode 100 forces reference inactive, 101 forces it active
// R5 - forced mode still raises compare flags and requests
// R6 - registers decoded at the twelve listed offsets, 16-bit wide
// R7 - control bit 0 runs or stops the counter; software sets it
// R8 - trigger mode lets hardware set the run bit on a trigger
// R9 - bit 1 clear allows update on overflow, software or slave; set blocks
// R10 - each update copies buffered reload, prescale and compare to active copies
// R11 - bit 2 set limits update flag and request to overflow only
// R12 - bit 7 clear: reload write acts at once; set: at next update
// R13 - bits 9:8 pick sampling period of one, two or four clocks
// R14 - control register resets to zero; bits 6:3 and 15:10 reserved
// R15 - pwm mode 1: reference active while counter below compare
// R16 - period follows reload value, pulse width follows compare value
// R17 - reserved bits read zero, ignore writes; divider code 11 reserved
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "spt_defs.vh"

module spt_timer #(
   parameter ADDR_W = 8,
   parameter CNT_W = 16
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [ADDR_W-1:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire trigger_in,
   output reg channel_out,
   output reg channel_out_en,
   output reg update_req,
   output reg compare_req
);
   reg [15:0] control_one;
   reg [15:0] slave_control;
   reg [15:0] irq_dma_enable;
   reg [15:0] status_flags;
   reg [15:0] channel_mode;
   reg [15:0] channel_enable;
   reg [15:0] option_select;
   reg [CNT_W-1:0] counter_value;
   reg [CNT_W-1:0] prescale_value;
   reg [CNT_W-1:0] reload_value;
   reg [CNT_W-1:0] compare_value;
   reg [CNT_W-1:0] active_prescale;
   reg [CNT_W-1:0] active_reload;
   reg [CNT_W-1:0] active_compare;
   reg [CNT_W-1:0] prescale_count;
   reg output_reference;
   reg count_moved;
   reg [ADDR_W-1:0] wr_addr;
   reg wr_pending;
   reg trig_meta;
   reg trig_sync;
   reg trig_sampled;
   reg trig_last;
   reg [CNT_W-1:0] next_counter;
   reg [15:0] rd_mux;
   wire sample_tick;
   wire addr_phase;
   wire wr_now;
   wire [15:0] wdata;
   wire trig_edge;
   wire count_run_bit;
   wire update_block_bit;
   wire update_source_select;
   wire reload_buffer_enable;
   wire [1:0] channel_direction_select;
   wire [2:0] output_compare_mode_field;
   wire force_update_bit;
   wire force_compare_bit;
   wire slave_update;
   wire overflow;
   wire count_tick;
   wire update_event;
   wire update_flag_set;
   wire compare_hit;
   wire compare_event;
   wire [CNT_W-1:0] period_end;
   wire rd_compare;

   // register hit test shared by write and read decode
   function is_reg;
      input [ADDR_W-1:0] a;
      input [7:0] off;
      begin
         is_reg = (a == off[ADDR_W-1:0]);
      end
   endfunction

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_phase = hsel & hready & htrans[1];
   assign wr_now = wr_pending;
   assign wdata = hwdata[15:0];
   assign rd_compare = addr_phase & ~hwrite & is_reg(haddr, `SPT_OFF_CHANNEL_ONE_COMPARE);

   assign count_run_bit = control_one[`SPT_CTL_COUNT_RUN];
   assign update_block_bit = control_one[`SPT_CTL_UPDATE_BLOCK];
   assign update_source_select = control_one[`SPT_CTL_UPDATE_SOURCE];
   assign reload_buffer_enable = control_one[`SPT_CTL_RELOAD_BUFFER];
   assign channel_direction_select = channel_mode[`SPT_CCM_DIR_HI:`SPT_CCM_DIR_LO];
   assign output_compare_mode_field = channel_mode[`SPT_CCM_MODE_HI:`SPT_CCM_MODE_LO];
   assign force_update_bit = wr_now & is_reg(wr_addr, `SPT_OFF_EVENT_GENERATE) & wdata[`SPT_EVG_UPDATE];
   assign force_compare_bit = wr_now & is_reg(wr_addr, `SPT_OFF_EVENT_GENERATE) & wdata[`SPT_EVG_COMPARE];

   // ahb address phase capture, writes land in the data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
         wr_addr <= {ADDR_W{1'b0}};
      end else begin
         wr_pending <= addr_phase & hwrite & (hsize == 3'b010);
         if (addr_phase)
            wr_addr <= haddr;
      end
   end

   // trigger pin sync, filter sampling and edge detect
   spt_sample_div u_sample_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .div_sel(control_one[`SPT_CTL_DIV_HI:`SPT_CTL_DIV_LO]),
      .sample_tick(sample_tick)
   );

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
         trig_sampled <= 1'b0;
         trig_last <= 1'b0;
      end else begin
         trig_meta <= trigger_in;
         trig_sync <= trig_meta;
         if (sample_tick) // see R13
            trig_sampled <= trig_sync;
         trig_last <= trig_sampled;
      end
   end

   assign trig_edge = trig_sampled & ~trig_last & slave_control[`SPT_SLV_TRIGGER_MODE];
   assign slave_update = trig_edge & slave_control[`SPT_SLV_TRIGGER_UPDATE];

   // time base
   assign period_end = reload_buffer_enable ? active_reload : reload_value; // see R12
   assign count_tick = count_run_bit & (prescale_count == active_prescale);
   assign overflow = count_tick & (counter_value == period_end); // see R16
   assign update_event = ~update_block_bit & (overflow | force_update_bit | slave_update); // see R9
   assign update_flag_set = update_event & (~update_source_select | overflow); // see R11

   always @* begin
      next_counter = counter_value;
      if (update_event & ~overflow)
         next_counter = {CNT_W{1'b0}};
      else if (overflow)
         next_counter = {CNT_W{1'b0}};
      else if (count_tick)
         next_counter = counter_value + {{(CNT_W-1){1'b0}}, 1'b1};
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         counter_value <= {CNT_W{1'b0}};
         prescale_count <= {CNT_W{1'b0}};
         active_prescale <= {CNT_W{1'b0}};
         active_reload <= {CNT_W{1'b0}};
         active_compare <= {CNT_W{1'b0}};
         count_moved <= 1'b0;
      end else begin
         count_moved <= count_tick | update_event;
         if (wr_now & is_reg(wr_addr, `SPT_OFF_COUNTER_VALUE))
            counter_value <= wdata[CNT_W-1:0];
         else
            counter_value <= next_counter;
         if (update_event | count_tick | ~count_run_bit)
            prescale_count <= {CNT_W{1'b0}};
         else
            prescale_count <= prescale_count + {{(CNT_W-1){1'b0}}, 1'b1};
         if (update_event) begin // see R10
            active_prescale <= prescale_value;
            active_reload <= reload_value;
            active_compare <= compare_value;
         end else if (~channel_mode[`SPT_CCM_CMP_BUFFER]) begin
            active_compare <= compare_value;
         end
      end
   end

   // compare channel
   assign compare_hit = count_moved & (counter_value == active_compare);
   assign compare_event = (compare_hit | force_compare_bit)
      & (channel_direction_select == `SPT_CCM_DIR_OUTPUT); // see R5

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         output_reference <= 1'b0;
      end else begin
         case (output_compare_mode_field)
            `SPT_MODE_FREEZE: output_reference <= output_reference;
            `SPT_MODE_SET_ON_MATCH: output_reference <= output_reference | compare_hit;
            `SPT_MODE_CLEAR_ON_MATCH: output_reference <= output_reference & ~compare_hit;
            `SPT_MODE_TOGGLE: output_reference <= output_reference ^ compare_hit;
            `SPT_MODE_FORCE_LOW: output_reference <= 1'b0; // see R2 R4
            `SPT_MODE_FORCE_HIGH: output_reference <= 1'b1; // see R2 R4
            `SPT_MODE_PWM_ONE: output_reference <= (next_counter < active_compare); // see R15 R16
            `SPT_MODE_PWM_TWO: output_reference <= ~(next_counter < active_compare); // see R1 R16
            default: output_reference <= 1'b0;
         endcase
      end
   end

   // pin drive, only while the channel is an output
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         channel_out <= 1'b0;
         channel_out_en <= 1'b0;
         update_req <= 1'b0;
         compare_req <= 1'b0;
      end else begin
         channel_out_en <= channel_enable[`SPT_CEN_OUT_ENABLE]
            & (channel_direction_select == `SPT_CCM_DIR_OUTPUT); // see R3
         channel_out <= channel_enable[`SPT_CEN_OUT_ENABLE]
            & (channel_direction_select == `SPT_CCM_DIR_OUTPUT)
            & (output_reference ^ channel_enable[`SPT_CEN_POLARITY]);
         update_req <= update_flag_set; // see R11
         compare_req <= compare_event; // see R5
      end
   end

   // register writes
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control_one <= `SPT_RESET_VALUE; // see R14
         slave_control <= `SPT_RESET_VALUE;
         irq_dma_enable <= `SPT_RESET_VALUE;
         channel_mode <= `SPT_RESET_VALUE;
         channel_enable <= `SPT_RESET_VALUE;
         option_select <= `SPT_RESET_VALUE;
         prescale_value <= {CNT_W{1'b0}};
         reload_value <= {CNT_W{1'b0}};
         compare_value <= {CNT_W{1'b0}};
      end else begin
         if (wr_now & is_reg(wr_addr, `SPT_OFF_CONTROL_ONE)) begin
            control_one <= wdata & `SPT_CTL_MASK; // see R7 R17
            if (trig_edge)
               control_one[`SPT_CTL_COUNT_RUN] <= 1'b1;
         end else if (trig_edge) begin
            control_one[`SPT_CTL_COUNT_RUN] <= 1'b1; // see R8
         end
         if (wr_now & is_reg(wr_addr, `SPT_OFF_SLAVE_CONTROL))
            slave_control <= wdata & `SPT_SLV_MASK;
         if (wr_now & is_reg(wr_addr, `SPT_OFF_IRQ_DMA_ENABLE))
            irq_dma_enable <= wdata & `SPT_IEN_MASK;
         if (wr_now & is_reg(wr_addr, `SPT_OFF_CHANNEL_MODE))
            channel_mode <= wdata & `SPT_CCM_MASK;
         if (wr_now & is_reg(wr_addr, `SPT_OFF_CHANNEL_ENABLE))
            channel_enable <= wdata & `SPT_CEN_MASK;
         if (wr_now & is_reg(wr_addr, `SPT_OFF_OPTION_SELECT))
            option_select <= wdata & `SPT_OPT_MASK;
         if (wr_now & is_reg(wr_addr, `SPT_OFF_PRESCALER_VALUE))
            prescale_value <= wdata[CNT_W-1:0];
         if (wr_now & is_reg(wr_addr, `SPT_OFF_RELOAD_VALUE))
            reload_value <= wdata[CNT_W-1:0]; // see R12
         if (wr_now & is_reg(wr_addr, `SPT_OFF_CHANNEL_ONE_COMPARE))
            compare_value <= wdata[CNT_W-1:0];
      end
   end

   // status flags: write zero clears, a set in the same cycle wins
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_flags <= `SPT_RESET_VALUE;
      end else begin
         if (update_flag_set) // see R11
            status_flags[`SPT_STS_UPDATE] <= 1'b1;
         else if (wr_now & is_reg(wr_addr, `SPT_OFF_STATUS_FLAGS) & ~wdata[`SPT_STS_UPDATE])
            status_flags[`SPT_STS_UPDATE] <= 1'b0;
         if (compare_event) // see R5
            status_flags[`SPT_STS_COMPARE] <= 1'b1;
         else if ((wr_now & is_reg(wr_addr, `SPT_OFF_STATUS_FLAGS) & ~wdata[`SPT_STS_COMPARE]) | rd_compare)
            status_flags[`SPT_STS_COMPARE] <= 1'b0;
      end
   end

   // read decode, unmapped offsets read zero
   always @* begin // see R6
      rd_mux = 16'h0000;
      if (is_reg(haddr, `SPT_OFF_CONTROL_ONE))
         rd_mux = control_one;
      else if (is_reg(haddr, `SPT_OFF_SLAVE_CONTROL))
         rd_mux = slave_control;
      else if (is_reg(haddr, `SPT_OFF_IRQ_DMA_ENABLE))
         rd_mux = irq_dma_enable;
      else if (is_reg(haddr, `SPT_OFF_STATUS_FLAGS))
         rd_mux = status_flags;
      else if (is_reg(haddr, `SPT_OFF_CHANNEL_MODE))
         rd_mux = channel_mode;
      else if (is_reg(haddr, `SPT_OFF_CHANNEL_ENABLE))
         rd_mux = channel_enable;
      else if (is_reg(haddr, `SPT_OFF_COUNTER_VALUE))
         rd_mux = counter_value;
      else if (is_reg(haddr, `SPT_OFF_PRESCALER_VALUE))
         rd_mux = prescale_value;
      else if (is_reg(haddr, `SPT_OFF_RELOAD_VALUE))
         rd_mux = reload_value;
      else if (is_reg(haddr, `SPT_OFF_CHANNEL_ONE_COMPARE))
         rd_mux = compare_value;
      else if (is_reg(haddr, `SPT_OFF_OPTION_SELECT))
         rd_mux = option_select;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (addr_phase & ~hwrite)
         hrdata <= {16'h0000, rd_mux}; // see R17
   end
endmodule // spt_timer

`default_nettype wire

//--- verification/spt_timer_sva.sv
// port checker for the single channel timer
`timescale 1ns/100ps
`default_nettype none
module spt_timer_chk #(
   parameter ADDR_W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic trigger_in,
   input wire logic channel_out,
   input wire logic channel_out_en,
   input wire logic update_req,
   input wire logic compare_req
);
   logic a_rd, a_wr;
   logic [7:0] a_ad;
   logic [15:0] ctl, ccm, cen;
   logic [3:0] age;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // shadow of control, mode and enable writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_rd <= 1'b0;
         a_wr <= 1'b0;
         a_ad <= 8'h00;
         ctl <= 16'h0000;
         ccm <= 16'h0000;
         cen <= 16'h0000;
         age <= 4'h0;
      end else begin
         a_rd <= hsel && hready && htrans[1] && !hwrite;
         a_wr <= hsel && hready && htrans[1] && hwrite && hsize == 3'b010;
         a_ad <= haddr[7:0];
         if (a_wr && a_ad == 8'h00) ctl <= hwdata[15:0];
         if (a_wr && a_ad == 8'h18) ccm <= hwdata[15:0];
         if (a_wr && a_ad == 8'h20) cen <= hwdata[15:0];
         if (a_wr && (a_ad == 8'h00 || a_ad == 8'h18 || a_ad == 8'h20)) age <= 4'h0;
         else if (age != 4'hf) age <= age + 4'h1;
      end
   end
   AST_READY:
      assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   AST_UPPER:
      assert property (a_rd |-> hrdata[31:16] == 16'h0000) else $error("upper read bits set");
   AST_CTL_RSV:
      assert property (a_rd && a_ad == 8'h00 |-> hrdata[6:3] == 4'h0 && hrdata[15:10] == 6'h00)
         else $error("control reserved bits set");
   AST_UNMAPPED:
      assert property (a_rd && a_ad == 8'h04 |-> hrdata == 32'h0000_0000) else $error("unmapped read not zero");
   AST_EVG_RD:
      assert property (a_rd && a_ad == 8'h14 |-> hrdata[15:0] == 16'h0000) else $error("event register reads back");
   AST_NO_UPD:
      assert property (ctl[1] && age >= 4'h4 |-> !update_req) else $error("update while blocked");
   AST_FORCE_LO:
      assert property (ccm[6:4] == 3'b100 && ccm[1:0] == 2'b00 && !cen[1] && age >= 4'h4 |-> !channel_out)
         else $error("forced low not low");
   AST_FORCE_HI:
      assert property (ccm[6:4] == 3'b101 && ccm[1:0] == 2'b00 && cen[1:0] == 2'b01 && age >= 4'h4
         |-> $stable(channel_out) && channel_out) else $error("forced high not high");
   AST_DIR:
      assert property (ccm[1:0] != 2'b00 && age >= 4'h4 |-> !channel_out) else $error("input channel drives");
   AST_OUT_EN:
      assert property (age >= 4'h4 |-> channel_out_en == (cen[0] && ccm[1:0] == 2'b00))
         else $error("pin drive enable wrong");
endmodule // spt_timer_chk
bind spt_timer spt_timer_chk #(.ADDR_W(ADDR_W)) spt_timer_chk_inst (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trigger_in(trigger_in),
   .channel_out(channel_out), .channel_out_en(channel_out_en), .update_req(update_req),
   .compare_req(compare_req));
`default_nettype wire

//--- verification/spt_pin_load.sv
// channel pin with pull-down load
`timescale 1ns/100ps
`default_nettype none
module spt_pin_load (
   input wire logic channel_out,
   input wire logic channel_out_en,
   output logic pin
);
   // undriven pin falls to the pull-down level
   assign pin = channel_out_en ? channel_out : 1'b0;
endmodule // spt_pin_load
`default_nettype wire

//--- verification/tb.sv
// register and waveform testbench for the single channel timer
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic hclk, hresetn, hsel, hwrite, trigger_in;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, r;
   wire hready, hresp, channel_out, channel_out_en, update_req, compare_req, pin;
   wire [31:0] hrdata;
   int mismatches, n_tests, o, u, c;
   logic [7:0] offs [14] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h34,
      8'h50, 8'h04, 8'h30};
   logic [7:0] md [8] = '{8'h60, 8'h70, 8'h40, 8'h50, 8'h30, 8'h10, 8'h00, 8'h20};
   int ones [8] = '{50, 30, 0, 80, 40, 80, 80, 0};
   spt_timer spt_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .trigger_in(trigger_in), .channel_out(channel_out), .channel_out_en(channel_out_en),
      .update_req(update_req), .compare_req(compare_req));
   spt_pin_load spt_pin_load_inst (.channel_out(channel_out), .channel_out_en(channel_out_en), .pin(pin));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   task stop_test;
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // one single word transfer, address phase then data phase
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(r, e);
   endtask
   // counts pin highs, update and compare pulses
   task run(input int n);
      o = 0;
      u = 0;
      c = 0;
      repeat (n) begin
         @(posedge hclk);
         o += (pin === 1'b1);
         u += (update_req === 1'b1);
         c += (compare_req === 1'b1);
      end
   endtask
   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      stop_test;
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      trigger_in = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (offs[i]) rd(offs[i], 32'h0000_0000);
      wr(8'h00, 32'h0000_ffff);
      rd(8'h00, 32'h0000_0387);
      wr(8'h00, 32'h0000_0000);
      wr(8'h04, 32'h0000_ffff);
      rd(8'h04, 32'h0000_0000);
      wr(8'h0c, 32'h0000_ffff);
      rd(8'h0c, 32'h0000_0003);
      wr(8'h50, 32'h0000_ffff);
      rd(8'h50, 32'h0000_0003);
      wr(8'h28, 32'h0000_0000);
      wr(8'h2c, 32'h0000_0007);
      wr(8'h34, 32'h0000_0005);
      wr(8'h20, 32'h0000_0001);
      wr(8'h00, 32'h0000_0081);
      foreach (md[i]) begin
         wr(8'h18, {24'h00_0000, md[i]});
         run(16);
         run(80);
         chk(o, ones[i]);
         chk(u, 10);
         chk(c, 10);
      end
      // inverted polarity on a forced inactive reference
      wr(8'h18, 32'h0000_0040);
      wr(8'h20, 32'h0000_0003);
      run(16);
      run(80);
      chk(o, 80);
      // flags: clear, forced compare, clear on compare read
      wr(8'h00, 32'h0000_0080);
      wr(8'h10, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      wr(8'h14, 32'h0000_0002);
      rd(8'h10, 32'h0000_0002);
      rd(8'h34, 32'h0000_0005);
      rd(8'h10, 32'h0000_0000);
      wr(8'h00, 32'h0000_0081);
      wr(8'h20, 32'h0000_0001);
      wr(8'h18, 32'h0000_0051);
      run(16);
      run(80);
      chk(o, 0);
      wr(8'h18, 32'h0000_0060);
      wr(8'h28, 32'h0000_0001);
      run(40);
      run(80);
      chk(u, 5);
      wr(8'h28, 32'h0000_0000);
      run(40);
      wr(8'h00, 32'h0000_0083);
      run(8);
      run(80);
      chk(u, 0);
      wr(8'h00, 32'h0000_0000);
      wr(8'h24, 32'h0000_0000);
      wr(8'h2c, 32'h0000_0003);
      wr(8'h00, 32'h0000_0001);
      run(8);
      run(80);
      chk(u, 20);
      wr(8'h00, 32'h0000_0004);
      wr(8'h14, 32'h0000_0001);
      run(8);
      chk(u, 0);
      wr(8'h00, 32'h0000_0000);
      wr(8'h14, 32'h0000_0001);
      run(8);
      chk(u, 1);
      wr(8'h00, 32'h0000_0200);
      wr(8'h2c, 32'h0000_ffff);
      wr(8'h08, 32'h0000_0003);
      trigger_in <= 1'b1;
      run(20);
      chk(u, 1);
      rd(8'h00, 32'h0000_0201);
      trigger_in <= 1'b0;
      stop_test;
   end
endmodule // tb
`default_nettype wire
